// ==== rtl/tvs_pkg.sv ====
// Package of constants shared by the tone and volume sound generator
package tvs_pkg;
   // Clock rates and the derived sound clock divider
   localparam int unsigned HCLK_HZ     = 40_000_000;   // Bus clock rate
   localparam int unsigned SND_CLK_HZ  = 10_000_000;   // Sound input clock rate
   localparam int unsigned SND_DIV     = HCLK_HZ / SND_CLK_HZ;
   localparam int unsigned DIV_W       = 2;            // Holds SND_DIV - 1
   localparam logic [1:0]  DIV_LAST    = 2'(SND_DIV - 1);
   localparam logic [1:0]  DIV_ZERO    = 2'h0;

   // Counter widths
   localparam int unsigned PER_W       = 9;            // Period counter
   localparam int unsigned TONE_W      = 6;            // Tone counter

   // Register indices (byte address is four times the index)
   localparam logic [17:0] IDX_CTRL    = 18'h0FFA5;    // sound_control
   localparam logic [17:0] IDX_VOL     = 18'h0FFA6;    // volume_target
   localparam logic [17:0] IDX_PER     = 18'h0FFA8;    // pwm_period_target
   localparam logic [17:0] IDX_TONE    = 18'h0FFAA;    // tone_divider_target

   // Control register fields and reset values
   localparam int unsigned CTRL_GATE_BIT = 4;          // clock_gate_on
   localparam int unsigned CTRL_MIX_BIT  = 1;          // output_mix_select
   localparam logic [7:0]  CTRL_RST      = 8'h00;
   localparam logic [15:0] REG16_RST     = 16'h0000;

   // AHB-Lite encodings
   localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0]  HTRANS_SEQ    = 2'h3;
   localparam logic        HRESP_OKAY    = 1'h0;
   localparam logic [31:0] RDATA_ZERO    = 32'h00000000;
endpackage

// ==== rtl/tvs_counter.sv ====
// Up counter that wraps to zero when it equals its compare target
`timescale 1ns/10ps
module tvs_counter #(
   parameter int unsigned W = 9
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Control
   input  wire logic         clr,
   input  wire logic         tick,
   input  wire logic [W-1:0] target,
   // Status
   output logic [W-1:0]      next,
   output logic              wrap
);
   logic [W-1:0] count_q;    // Current count

   // Match with the compare target, qualified by the count enable
   assign wrap = tick && (count_q == target);

   // Next value: cleared, wrapped, stepped or held
   always_comb begin
      if (clr) begin
         next = '0;
      end else if (wrap) begin
         next = '0;
      end else if (tick) begin
         next = W'(count_q + 1'b1);
      end else begin
         next = count_q;
      end
   end

   // Count register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= '0;
      end else begin
         count_q <= next;
      end
   end
endmodule

// ==== rtl/tvs_sound_gen.sv ====
// Tone and volume sound generator with AHB-Lite register slave
//
// Functional notes
// - Volume writes go via a compare buffer
// - PWM set on period match, cleared at volume
// - Mix clear: tone and PWM on separate pins
// - Control bit 1 selects separate or composite
// - Composite output is PWM AND tone
// - Period and tone buffers update only in step with tone
// - Period match clocks tone counter and PWM
// - Volume above period gives full duty
// - Zero volume stops PWM promptly
// - Control is 8 bits, resets to zero
// - Control bit 4 gates the sound clock
// - Target registers ignore writes while gated off
// - Period register 9 bits, upper bits zero
// - Tone register 6 bits, cleared by reset
// - Volume register 9 bits, resets to zero
// - Target reads return last value written while gated on
// - Counters wrap at buffer; tone divided by two
// - Sound clock is bus clock divided down
// - Zero volume reaches buffer next sound tick
// - Non-zero volume loads at tone counter match
`timescale 1ns/10ps
module tvs_sound_gen #(
   parameter int unsigned ADDR_W = 20
) (
   // Clock and reset
   input  wire logic              hclk,
   input  wire logic              hresetn,
   // AHB-Lite slave
   input  wire logic              hsel,
   input  wire logic [ADDR_W-1:0] haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic                   hreadyout,
   output logic                   hresp,
   output logic [31:0]            hrdata,
   // Sound pins
   output logic                   tone_out_pin,
   output logic                   amplitude_out_pin
);
   localparam int unsigned PW = tvs_pkg::PER_W;
   localparam int unsigned TW = tvs_pkg::TONE_W;

   // Software registers
   logic [7:0]    ctrl_q, ctrl_d;        // sound_control
   logic [PW-1:0] vol_q, vol_d;          // volume_target
   logic [PW-1:0] per_q, per_d;          // pwm_period_target
   logic [TW-1:0] tone_q, tone_d;        // tone_divider_target

   // Hardware buffers used by the generator
   logic [PW-1:0] vol_buf_q;             // Volume compare buffer
   logic [PW-1:0] per_buf_q;             // Period compare buffer
   logic [TW-1:0] tone_buf_q;            // Tone compare buffer

   // Generator state
   logic [1:0]    div_q;                 // Sound clock divider
   logic          tick;                  // One-cycle sound clock enable
   logic          gate;                  // clock_gate_on
   logic          mix;                   // output_mix_select
   logic [PW-1:0] per_next;              // Period counter next value
   logic          per_wrap;              // Period match pulse
   logic          tone_wrap;             // Tone counter match pulse
   logic          tone_sig_q;            // tone_signal, divide-by-two stage
   logic          pwm_q;                 // volume_signal, set/reset flop

   // Bus data phase state
   logic          wr_pend_q;             // Write in data phase
   logic [17:0]   wr_idx_q;              // Index of that write
   logic          addr_ok;               // Valid address phase
   logic [17:0]   a_idx;                 // Index of address phase

   assign gate = ctrl_q[tvs_pkg::CTRL_GATE_BIT];
   assign mix  = ctrl_q[tvs_pkg::CTRL_MIX_BIT];

   // Address phase accepted on selected NONSEQ or SEQ with bus ready
   assign addr_ok = hsel && hready &&
                    (htrans == tvs_pkg::HTRANS_NONSEQ || htrans == tvs_pkg::HTRANS_SEQ);
   assign a_idx   = haddr[19:2];

   // Capture write address phase for the following data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_idx_q  <= '0;
      end else if (hready) begin
         wr_pend_q <= addr_ok && hwrite;
         wr_idx_q  <= a_idx;
      end
   end

   // Next register values; only writable bits are stored
   always_comb begin
      ctrl_d = ctrl_q;
      vol_d  = vol_q;
      per_d  = per_q;
      tone_d = tone_q;
      if (wr_pend_q) begin
         case (wr_idx_q)
            tvs_pkg::IDX_CTRL: begin
               // Bit 0 and unused bits stay zero whatever is written
               ctrl_d = tvs_pkg::CTRL_RST;
               ctrl_d[tvs_pkg::CTRL_GATE_BIT] = hwdata[tvs_pkg::CTRL_GATE_BIT];
               ctrl_d[tvs_pkg::CTRL_MIX_BIT]  = hwdata[tvs_pkg::CTRL_MIX_BIT];
            end
            tvs_pkg::IDX_VOL: begin
               if (gate) begin
                  vol_d = hwdata[PW-1:0];
               end
            end
            tvs_pkg::IDX_PER: begin
               if (gate) begin
                  per_d = hwdata[PW-1:0];
               end
            end
            tvs_pkg::IDX_TONE: begin
               if (gate) begin
                  tone_d = hwdata[TW-1:0];
               end
            end
            default: begin
               // Unmapped writes are dropped
            end
         endcase
      end
   end

   // Software register file
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q <= tvs_pkg::CTRL_RST;
         vol_q  <= tvs_pkg::REG16_RST[PW-1:0];
         per_q  <= tvs_pkg::REG16_RST[PW-1:0];
         tone_q <= tvs_pkg::REG16_RST[TW-1:0];
      end else begin
         ctrl_q <= ctrl_d;
         vol_q  <= vol_d;
         per_q  <= per_d;
         tone_q <= tone_d;
      end
   end

   // Read data taken from next values so a read right after a write sees it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= tvs_pkg::RDATA_ZERO;
      end else if (hready) begin
         hrdata <= tvs_pkg::RDATA_ZERO;
         if (addr_ok && !hwrite) begin
            case (a_idx)
               tvs_pkg::IDX_CTRL: hrdata <= 32'(ctrl_d);
               tvs_pkg::IDX_VOL:  hrdata <= 32'(vol_d);
               tvs_pkg::IDX_PER:  hrdata <= 32'(per_d);
               tvs_pkg::IDX_TONE: hrdata <= 32'(tone_d);
               default:           hrdata <= tvs_pkg::RDATA_ZERO;
            endcase
         end
      end
   end

   // Slave never stalls and always answers OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= tvs_pkg::HRESP_OKAY;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= tvs_pkg::HRESP_OKAY;
      end
   end

   // Sound clock enable; divider idles at zero while gated off
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_q <= tvs_pkg::DIV_ZERO;
      end else if (!gate) begin
         div_q <= tvs_pkg::DIV_ZERO;
      end else if (div_q == tvs_pkg::DIV_LAST) begin
         div_q <= tvs_pkg::DIV_ZERO;
      end else begin
         div_q <= div_q + 2'h1;
      end
   end
   assign tick = gate && (div_q == tvs_pkg::DIV_LAST);

   // Period counter, stepped by the sound clock
   tvs_counter #(.W(PW)) u_per_cnt (
      .clk    (hclk),
      .rst_n  (hresetn),
      .clr    (!gate),
      .tick   (tick),
      .target (per_buf_q),
      .next   (per_next),
      .wrap   (per_wrap)
   );

   // Tone counter, stepped by the period match pulse
   tvs_counter #(.W(TW)) u_tone_cnt (
      .clk    (hclk),
      .rst_n  (hresetn),
      .clr    (!gate),
      .tick   (per_wrap),
      .target (tone_buf_q),
      .next   (),
      .wrap   (tone_wrap)
   );

   // Divide-by-two stage gives a square tone
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tone_sig_q <= 1'b0;
      end else if (!gate) begin
         tone_sig_q <= 1'b0;
      end else if (tone_wrap) begin
         tone_sig_q <= !tone_sig_q;
      end
   end

   // Frequency buffers follow the registers only at tone edges
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         per_buf_q  <= '0;
         tone_buf_q <= '0;
      end else if (!gate) begin
         per_buf_q  <= '0;
         tone_buf_q <= '0;
      end else if (tone_wrap) begin
         per_buf_q  <= per_q;
         tone_buf_q <= tone_q;
      end
   end

   // Volume buffer: zero loads on the next sound tick, other values wait for a tone edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         vol_buf_q <= '0;
      end else if (!gate) begin
         vol_buf_q <= '0;
      end else if (tick && vol_q == '0) begin
         vol_buf_q <= '0;
      end else if (tone_wrap) begin
         vol_buf_q <= vol_q;
      end
   end

   // PWM flop: cleared when the next count reaches the volume, set on wrap.
   // Comparing the next count gives exactly volume/(period+1) duty.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pwm_q <= 1'b0;
      end else if (!gate) begin
         pwm_q <= 1'b0;
      end else if (tick) begin
         if (vol_buf_q == '0 || per_next == vol_buf_q) begin
            pwm_q <= 1'b0;
         end else if (per_wrap) begin
            pwm_q <= 1'b1;
         end
      end
   end

   // Pin drivers, registered; amplitude pin rests low in composite mode
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tone_out_pin      <= 1'b0;
         amplitude_out_pin <= 1'b0;
      end else if (!gate) begin
         tone_out_pin      <= 1'b0;
         amplitude_out_pin <= 1'b0;
      end else if (mix) begin
         tone_out_pin      <= tone_sig_q && pwm_q;
         amplitude_out_pin <= 1'b0;
      end else begin
         tone_out_pin      <= tone_sig_q;
         amplitude_out_pin <= pwm_q;
      end
   end

   // Checks
   vol_zero_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (gate && tick && vol_buf_q == '0) |=> !pwm_q)
      else $error("pwm high with zero volume buffer");

   zero_stop_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (gate && vol_q == '0 && vol_buf_q != '0 && $stable(ctrl_q)) |-> ##[1:4] (vol_buf_q == '0))
      else $error("zero volume not loaded within one sound tick");

   full_duty_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (gate && tick && pwm_q && vol_buf_q > per_buf_q) |=> pwm_q)
      else $error("pwm dropped with volume above period");

   gated_pins_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !gate |=> (!tone_out_pin && !amplitude_out_pin))
      else $error("pins active while gated off");

   composite_and_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (gate && mix) |=> (tone_out_pin == ($past(tone_sig_q) && $past(pwm_q))))
      else $error("composite output not tone and pwm");

   separate_pins_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (gate && !mix) |=> (tone_out_pin == $past(tone_sig_q) && amplitude_out_pin == $past(pwm_q)))
      else $error("separate outputs wrong");

   buf_sync_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (gate && $past(gate) && (per_buf_q != $past(per_buf_q) || tone_buf_q != $past(tone_buf_q)))
      |-> $past(tone_wrap))
      else $error("frequency buffer changed off a tone edge");

   tone_toggle_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (gate && $past(gate) && tone_sig_q != $past(tone_sig_q)) |-> $past(tone_wrap))
      else $error("tone toggled without tone match");

   gated_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_pend_q && !gate && wr_idx_q == tvs_pkg::IDX_VOL) |=> $stable(vol_q))
      else $error("volume written while gated off");

   tick_space_a: assert property (@(posedge hclk) disable iff (!hresetn)
      tick |=> !tick [*3])
      else $error("sound tick spacing wrong");

   // A non-zero volume may only reach the buffer on a tone edge
   vol_sync_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (gate && $past(gate) && vol_buf_q != $past(vol_buf_q) && vol_buf_q != '0) |-> $past(tone_wrap))
      else $error("volume buffer loaded off a tone edge");

   // Period counter never runs past its compare buffer
   per_range_a: assert property (@(posedge hclk) disable iff (!hresetn)
      per_next <= per_buf_q)
      else $error("period count beyond its buffer");

   // Each period match raises the PWM while volume is non-zero
   pwm_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (gate && per_wrap && vol_buf_q != '0) |=> pwm_q)
      else $error("pwm not set on period match");

   // Once silenced with a zero buffer the PWM stays low
   silent_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (vol_buf_q == '0 && !pwm_q) |=> !pwm_q)
      else $error("pwm rose with zero volume buffer");

   // Composite mode keeps the amplitude pin quiet
   mix_amp_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (gate && mix) |=> !amplitude_out_pin)
      else $error("amplitude pin active in composite mode");
endmodule

// ==== tb/tvs_speaker_model.sv ====
// Loudspeaker load model that averages the high time of both sound pins
`timescale 1ns/10ps
module tvs_speaker_model (
   // Clock
   input  wire logic   hclk,
   // Sound pins from the generator
   input  wire logic   tone_in,
   input  wire logic   amp_in,
   // Averaging window opened by the bench
   input  wire logic   window,
   // High time seen in the window, as a filter would average it
   output int unsigned tone_hi,
   output int unsigned amp_hi
);
   logic win_q = 1'b0;   // Window level on the previous edge

   // Integrators restart when a window opens; only a clean 1 counts as high
   always @(posedge hclk) begin
      win_q <= window;
      if (window && !win_q) begin
         tone_hi <= (tone_in === 1'b1) ? 1 : 0;
         amp_hi  <= (amp_in === 1'b1) ? 1 : 0;
      end else if (window) begin
         tone_hi <= tone_hi + ((tone_in === 1'b1) ? 1 : 0);
         amp_hi  <= amp_hi + ((amp_in === 1'b1) ? 1 : 0);
      end
   end
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the tone and volume sound generator
`timescale 1ns/10ps
module tb;
   // Clock, reset and bus master outputs
   logic        hclk    = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel    = 1'b0;
   logic [19:0] haddr   = 20'h00000;
   logic [1:0]  htrans  = 2'h0;
   logic        hwrite  = 1'b0;
   logic [2:0]  hsize   = 3'h2;          // Whole words only
   logic [31:0] hwdata  = 32'h00000000;
   // Slave answers and sound pins
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic        tone_out_pin;
   logic        amplitude_out_pin;
   // Listening window and averaged high times
   logic        window  = 1'b0;
   int unsigned tone_hi;
   int unsigned amp_hi;
   int          mismatches = 0;
   int          compares   = 0;
   // Byte addresses are four times the register index
   localparam logic [19:0] A_CTRL = {tvs_pkg::IDX_CTRL, 2'h0};
   localparam logic [19:0] A_VOL  = {tvs_pkg::IDX_VOL, 2'h0};
   localparam logic [19:0] A_PER  = {tvs_pkg::IDX_PER, 2'h0};
   localparam logic [19:0] A_TONE = {tvs_pkg::IDX_TONE, 2'h0};

   // 40 MHz bus clock
   always #12.5 hclk = ~hclk;

   tvs_sound_gen uut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .tone_out_pin(tone_out_pin), .amplitude_out_pin(amplitude_out_pin)
   );

   tvs_speaker_model spk (
      .hclk(hclk), .tone_in(tone_out_pin), .amp_in(amplitude_out_pin),
      .window(window), .tone_hi(tone_hi), .amp_hi(amp_hi)
   );

   // Counts, verdict and end of run
   task automatic wrap_up;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // One comparison, reported at once on a miss
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   // Next edge with ready high; a hang ends the run
   task automatic wait_ready;
      int n;
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1) begin
         n++;
         if (n > 64) begin
            mismatches++;
            $display("unexpected at %0t: bus never ready", $time);
            wrap_up();
         end
         @(posedge hclk);
      end
   endtask

   // Single word transfer: address phase, then data phase
   task automatic bus(input logic wr, input logic [19:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= tvs_pkg::HTRANS_NONSEQ;
      hwrite <= wr;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready();
      q = hrdata;
      chk(32'(hresp), 32'(tvs_pkg::HRESP_OKAY));
      hsel   <= 1'b0;
   endtask

   task automatic wr(input logic [19:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [19:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h00000000, q);
      chk(q, exp);
   endtask

   // Let the speaker average n cycles, then compare high times
   task automatic listen(input int unsigned n, input int unsigned et, input int unsigned ea);
      @(posedge hclk);
      window <= 1'b1;
      repeat (n) @(posedge hclk);
      window <= 1'b0;
      @(posedge hclk);
      chk(32'(tone_hi), 32'(et));
      chk(32'(amp_hi), 32'(ea));
   endtask

   // Main sequence; 576 cycles span whole tone and PWM periods
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      // Reset values and an unmapped hole
      rd(A_CTRL, 32'h00000000);
      rd(A_VOL, 32'h00000000);
      rd(A_PER, 32'h00000000);
      rd(A_TONE, 32'h00000000);
      rd(20'h00010, 32'h00000000);
      listen(96, 0, 0);
      // Gated off: the volume write is dropped
      wr(A_VOL, 32'h00000003);
      rd(A_VOL, 32'h00000000);
      // Only gate and mix bits stick; bit 0 always written as zero
      wr(A_CTRL, 32'h000000FE);
      rd(A_CTRL, 32'h00000012);
      wr(A_CTRL, 32'h00000010);
      rd(A_CTRL, 32'h00000010);
      // Period 5, tone 2, volume 3; upper bits read back as zero
      wr(A_PER, 32'h0000FE05);
      wr(A_TONE, 32'h0000FFC2);
      wr(A_VOL, 32'h00000003);
      rd(A_PER, 32'h00000005);
      rd(A_TONE, 32'h00000002);
      rd(A_VOL, 32'h00000003);
      // Separate pins: tone 50 percent, PWM 3 ticks of every 6
      repeat (400) @(posedge hclk);
      listen(576, 288, 288);
      // Volume above the period target holds the PWM high
      wr(A_VOL, 32'h00000007);
      repeat (400) @(posedge hclk);
      listen(576, 288, 576);
      // Zero volume silences the PWM within a few cycles
      wr(A_VOL, 32'h00000000);
      repeat (10) @(posedge hclk);
      listen(576, 288, 0);
      // Composite: tone AND PWM on one pin, amplitude pin quiet
      wr(A_CTRL, 32'h00000012);
      wr(A_VOL, 32'h00000003);
      repeat (400) @(posedge hclk);
      listen(576, 144, 0);
      wr(A_VOL, 32'h00000000);
      repeat (10) @(posedge hclk);
      listen(576, 0, 0);
      // Gate off again: pins low, target writes dropped, values kept
      wr(A_CTRL, 32'h00000000);
      wr(A_PER, 32'h00000009);
      rd(A_PER, 32'h00000005);
      listen(576, 0, 0);
      wrap_up();
   end
endmodule
